// >>> verilog/cgpm_top.sv
// clock generation control and low power mode sequencing with axi4-lite registers
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cgpm_defines.svh"
module cgpm_top #(
  parameter int WAIT_BASE = `CGPM_WAIT_BASE,
  parameter int ADDR_W    = 6
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 por_n,
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output logic                      wready,
  output logic [1:0]                bresp,
  output logic                      bvalid,
  input  wire logic                 bready,
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic                 arvalid,
  output logic                      arready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  output logic                      rvalid,
  input  wire logic                 rready,
  input  wire logic                 low_speed_osc,
  input  wire logic                 high_speed_osc,
  input  wire logic                 main_osc,
  input  wire logic                 sub_osc,
  input  wire logic                 pll_clk,
  input  wire logic                 touch_sensing_unit_clk,
  input  wire logic                 wait_insn,
  input  wire logic                 irq_pending,
  input  wire logic                 snooze_req,
  input  wire logic                 snooze_end,
  output logic                      clock_output_pin,
  output logic [6:0]                pll_mult_x2,
  output logic                      pll_code_ok,
  output logic                      main_osc_stop,
  output logic                      main_osc_drive_bit,
  output logic                      main_osc_stable,
  output logic                      subclock_stop_bit,
  output cgpm_pkg::cgpm_ticks_t     clk_ticks,
  output logic [31:0]               module_stop,
  output cgpm_pkg::cgpm_opmode_t    op_mode,
  output cgpm_pkg::cgpm_halt_t      halt,
  output logic                      cpu_restart,
  output cgpm_pkg::cgpm_state_t     state
);

  if (WAIT_BASE < 1 || WAIT_BASE > 1024) begin : g_chk
    $error("WAIT_BASE must lie in 1..1024");
  end
  if (ADDR_W < 6) begin : g_chk_a
    $error("ADDR_W must be at least 6");
  end

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // tick when the low code bits of a free counter are all ones
  function automatic logic div_tick(input logic [6:0] cnt, input logic [2:0] code);
    logic [6:0] mask;
    mask = 7'((8'h01 << code) - 8'h01);
    return &(cnt | ~mask);
  endfunction : div_tick

  // wait length in low speed oscillator cycles
  function automatic logic [17:0] wait_cycles(input logic [4:0] code);
    logic [4:0] c;
    c = (code > `CGPM_WAIT_MAX) ? `CGPM_WAIT_MAX : code;
    if (c == 5'h00) return 18'h00000;
    return 18'(18'(WAIT_BASE) << (c - 5'h01));
  endfunction : wait_cycles

  //////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [5:0]  pll_field;
  logic [4:0]  wait_field;
  logic [3:0]  ckout_sel;
  logic [2:0]  ckout_div;
  logic [14:0] div_fields;
  logic        deep_sel;
  logic        standby_sel;
  logic        snooze_en;
  logic        aw_hold;
  logic        w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic [31:0] rd_mux;
  logic        rd_ok;
  logic [31:0] old_val;
  logic        wr_ok;

  assign awready = !aw_hold && !bvalid;
  assign wready  = !w_hold && !bvalid;
  assign arready = !rvalid;
  assign wr_fire = aw_hold && w_hold && !bvalid;

  // read view of every register, also used as the base of a write
  function automatic logic [31:0] view(input logic [ADDR_W-1:0] a);
    if (a == `CGPM_OFS_PLL) return {18'h0, pll_field, 8'h00};
    else if (a == `CGPM_OFS_SUBOSC) return {31'h0, subclock_stop_bit};
    else if (a == `CGPM_OFS_WAIT) return {27'h0, wait_field};
    else if (a == `CGPM_OFS_CKOUT) return {17'h0, ckout_div, ckout_sel, 8'h00};
    else if (a == `CGPM_OFS_MOFUNC) return 32'(main_osc_drive_bit) << `CGPM_DRIVE_BIT;
    else if (a == `CGPM_OFS_CLKDIV) return {17'h0, div_fields};
    else if (a == `CGPM_OFS_MSTOP) return module_stop;
    else if (a == `CGPM_OFS_PWR) return {24'h0, snooze_en, standby_sel, deep_sel, 3'h0, op_mode};
    else if (a == `CGPM_OFS_STATUS) return {27'h0, state, 1'b0, main_osc_stable};
    else if (a == `CGPM_OFS_MOSC) return {31'h0, main_osc_stop};
    else return 32'h0;
  endfunction : view

  // address decode of mapped words
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a[1:0] == 2'b00 && a <= `CGPM_OFS_MOSC;
  endfunction : mapped

  always_comb begin
    old_val = merge(view(aw_addr), w_data, w_strb);
    wr_ok   = mapped(aw_addr) && aw_addr != `CGPM_OFS_STATUS;
    rd_mux  = view(araddr);
    rd_ok   = mapped(araddr);
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `CGPM_RESP_OK;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_ok ? `CGPM_RESP_OK : `CGPM_RESP_ERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0;
      rresp  <= `CGPM_RESP_OK;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= rd_ok ? `CGPM_RESP_OK : `CGPM_RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // control registers set to their reset values by rst_n only, not by por_n
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_field          <= `CGPM_PLL_RST;
      wait_field         <= 5'h00;
      ckout_sel          <= 4'h0;
      ckout_div          <= 3'h0;
      main_osc_drive_bit <= 1'b0;
      div_fields         <= 15'h0;
      module_stop        <= `CGPM_MSTOP_RST;
      op_mode            <= cgpm_pkg::OPM_HIGH;
      deep_sel           <= 1'b0;
      standby_sel        <= 1'b0;
      snooze_en          <= 1'b0;
      main_osc_stop      <= 1'b1;
    end else if (wr_fire) begin
      if (aw_addr == `CGPM_OFS_PLL) pll_field <= old_val[`CGPM_PLL_LSB +: 6];
      else if (aw_addr == `CGPM_OFS_WAIT) wait_field <= old_val[4:0];
      else if (aw_addr == `CGPM_OFS_CKOUT) begin
        ckout_sel <= old_val[`CGPM_CKSEL_LSB +: 4];
        ckout_div <= old_val[`CGPM_CKDIV_LSB +: 3];
      end else if (aw_addr == `CGPM_OFS_MOFUNC) begin
        main_osc_drive_bit <= old_val[`CGPM_DRIVE_BIT];
      end else if (aw_addr == `CGPM_OFS_CLKDIV) div_fields <= old_val[14:0];
      else if (aw_addr == `CGPM_OFS_MSTOP) module_stop <= old_val;
      else if (aw_addr == `CGPM_OFS_PWR) begin
        op_mode     <= cgpm_pkg::cgpm_opmode_t'(old_val[1:0]);
        deep_sel    <= old_val[5];
        standby_sel <= old_val[6];
        snooze_en   <= old_val[7];
      end else if (aw_addr == `CGPM_OFS_MOSC) main_osc_stop <= old_val[0];
    end
  end

  // sub-clock stop bit survives every reset except power-on
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) subclock_stop_bit <= 1'b0;
    else if (wr_fire && aw_addr == `CGPM_OFS_SUBOSC) subclock_stop_bit <= old_val[0];
  end

  //////////////////////////////////////////////////////////////////////////////
  // pll multiplier decode, twice the factor
  always_comb begin
    pll_mult_x2 = 7'({1'b0, pll_field} + 7'h01);
    pll_code_ok = pll_field >= `CGPM_PLL_MIN && pll_field <= `CGPM_PLL_MAX;
  end

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers for the oscillator inputs
  logic [5:0] src_s1;
  logic [5:0] src_s2;
  logic [5:0] src_s3;
  logic [5:0] src_rise;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_s1 <= 6'h00;
      src_s2 <= 6'h00;
      src_s3 <= 6'h00;
    end else begin
      src_s1 <= {touch_sensing_unit_clk, pll_clk, sub_osc, main_osc, high_speed_osc,
                 low_speed_osc};
      src_s2 <= src_s1;
      src_s3 <= src_s2;
    end
  end
  assign src_rise = src_s2 & ~src_s3;

  //////////////////////////////////////////////////////////////////////////////
  // main oscillator stabilization wait, counted on low speed oscillator edges
  logic [17:0] wait_cnt;
  logic        stop_d;
  logic        osc_start;
  assign osc_start = stop_d && !main_osc_stop;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_d          <= 1'b1;
      wait_cnt        <= 18'h0;
      main_osc_stable <= 1'b0;
    end else begin
      stop_d <= main_osc_stop;
      if (main_osc_stop) begin
        wait_cnt        <= 18'h0;
        main_osc_stable <= 1'b0;
      end else if (osc_start) begin
        wait_cnt <= wait_cycles(wait_field);
      end else if (!main_osc_stable) begin
        if (wait_cnt == 18'h0) main_osc_stable <= 1'b1;
        else if (src_rise[0]) wait_cnt <= wait_cnt - 18'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // clock output source select and divider
  logic [2:0] src_idx;
  logic       src_ok;
  logic [6:0] ck_cnt;
  always_comb begin
    src_ok  = 1'b1;
    src_idx = 3'h0;
    case (ckout_sel)
      4'h0:    src_idx = 3'h0;
      4'h1:    src_idx = 3'h1;
      4'h2:    src_idx = 3'h2;
      4'h3:    src_idx = 3'h3;
      4'h4:    src_idx = 3'h4;
      4'h8:    src_idx = 3'h5;
      default: src_ok  = 1'b0;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ck_cnt           <= 7'h0;
      clock_output_pin <= 1'b0;
    end else if (!src_ok) begin
      clock_output_pin <= 1'b0; // prohibited source code holds the pin low
    end else if (ckout_div == 3'h0) begin
      clock_output_pin <= src_s2[src_idx];
    end else if (src_rise[src_idx]) begin
      ck_cnt <= ck_cnt + 7'h1;
      if (div_tick(ck_cnt, ckout_div - 3'h1)) clock_output_pin <= !clock_output_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // independent internal clock dividers, one tick per divided period
  logic [6:0] div_cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt   <= 7'h0;
      clk_ticks <= '0;
    end else begin
      div_cnt                    <= div_cnt + 7'h1;
      clk_ticks.system_clock     <= div_tick(div_cnt, div_fields[2:0]);
      clk_ticks.peripheral_clock <= div_tick(div_cnt, div_fields[6:4]);
      clk_ticks.converter_clock  <= div_tick(div_cnt, div_fields[10:8]);
      clk_ticks.flash_if_clock   <= div_tick(div_cnt, div_fields[14:12]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power state sequencing
  cgpm_pkg::cgpm_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      cgpm_pkg::ST_RUN: begin
        if (wait_insn) begin
          if (standby_sel) next_state = cgpm_pkg::ST_STANDBY;
          else if (deep_sel) next_state = cgpm_pkg::ST_DEEP;
          else next_state = cgpm_pkg::ST_SLEEP;
        end
      end
      cgpm_pkg::ST_SLEEP, cgpm_pkg::ST_DEEP: begin
        if (irq_pending) next_state = cgpm_pkg::ST_RUN;
      end
      cgpm_pkg::ST_STANDBY: begin
        if (irq_pending) next_state = cgpm_pkg::ST_RUN;
        else if (snooze_en && snooze_req) next_state = cgpm_pkg::ST_SNOOZE;
      end
      cgpm_pkg::ST_SNOOZE: begin
        if (irq_pending && snooze_end) next_state = cgpm_pkg::ST_RUN;
      end
      default: next_state = cgpm_pkg::ST_RUN;
    endcase
  end

  // state, halt requests and restart pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= cgpm_pkg::ST_RUN;
      halt        <= '0;
      cpu_restart <= 1'b0;
    end else begin
      state             <= next_state;
      cpu_restart       <= state != cgpm_pkg::ST_RUN && next_state == cgpm_pkg::ST_RUN;
      halt.cpu_halt     <= next_state != cgpm_pkg::ST_RUN;
      halt.ram_dtc_halt <= next_state == cgpm_pkg::ST_DEEP
                           || next_state == cgpm_pkg::ST_STANDBY;
      halt.flash_halt   <= next_state inside {cgpm_pkg::ST_DEEP, cgpm_pkg::ST_STANDBY,
                                              cgpm_pkg::ST_SNOOZE};
      // peripherals keep their own stop bits except in standby
      halt.periph_halt  <= next_state == cgpm_pkg::ST_STANDBY;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  pll_decode_a: assert property (
    pll_field == 6'h17 |-> pll_mult_x2 == 7'd24 && pll_code_ok)
    else $error("pll x12 code not decoded");
  wait_load_a: assert property (
    osc_start && wait_field == 5'h08 |=> wait_cnt == 18'(WAIT_BASE * 128) && !main_osc_stable)
    else $error("wait count not loaded");
  low_speed_osc_count_a: assert property (
    !osc_start && !main_osc_stop && wait_cnt != 18'h0 && !src_rise[0] |=> $stable(wait_cnt))
    else $error("wait counted without low speed edge");
  stable_clear_a: assert property (
    main_osc_stop |=> !main_osc_stable)
    else $error("stable flag kept while stopped");
  ckout_pass_a: assert property (
    ckout_sel == 4'h3 && ckout_div == 3'h0 |=> clock_output_pin == $past(src_s2[3]))
    else $error("clock output not routed");
  sleep_enter_a: assert property (
    state == cgpm_pkg::ST_RUN && wait_insn && !standby_sel && !deep_sel
    |=> state == cgpm_pkg::ST_SLEEP ##0 halt.cpu_halt && !halt.ram_dtc_halt)
    else $error("sleep not entered");
  wake_irq_a: assert property (
    state inside {cgpm_pkg::ST_SLEEP, cgpm_pkg::ST_DEEP} && irq_pending
    |=> state == cgpm_pkg::ST_RUN && cpu_restart ##1 !cpu_restart)
    else $error("no restart on interrupt");
  deep_halt_a: assert property (
    state == cgpm_pkg::ST_DEEP |-> halt.cpu_halt && halt.ram_dtc_halt)
    else $error("deep sleep halts wrong");
  snooze_go_a: assert property (
    state == cgpm_pkg::ST_STANDBY && !irq_pending && snooze_en && snooze_req
    |=> state == cgpm_pkg::ST_SNOOZE)
    else $error("snooze not entered");

  sleep_wake_c: cover property (state == cgpm_pkg::ST_SLEEP ##1 cpu_restart);
  snooze_c: cover property (state == cgpm_pkg::ST_SNOOZE ##1 state == cgpm_pkg::ST_RUN);
  stable_c: cover property ($rose(main_osc_stable));

endmodule : cgpm_top
`default_nettype wire

// >>> verilog/cgpm_defines.svh
// constants and register map of the clock generation and power mode block
// Notes on behaviour
// - pll multiplier field bits 13:8, code 7 is x4 up to code 23 x12 by halves
// - sub-clock stop bit is reset only by power-on reset
// - wait field bits 4:0, code 0 none, code 1 1024, doubling to code 8 131072
// - stabilization wait counts cycles of the low-speed oscillator, about 0.25 us
// - clock output source field bits 11:8 picks low, high, main, sub, pll, touch
// - clock output divider field bits 14:12 divides by 1 up to 128
// - system, peripheral, converter and flash clocks have independent dividers
// - each module halts on its own stop bit without touching others
// - sleep modes entered by control bits plus wait instruction, left by interrupt or reset
// - leaving sleep on an interrupt restarts the cpu to service it
// - four operating power modes apply in run, sleep, deep sleep and snooze
// - sleep halts cpu only; deep sleep also halts ram and transfer controller
// - units able to run in low power follow their own control bits; the code asserts periph_halt for all peripherals in standby
// - standby goes to snooze on a snooze request; interrupt plus end condition leaves
`ifndef CGPM_DEFINES_SVH
`define CGPM_DEFINES_SVH
`define CGPM_OFS_PLL     6'h00
`define CGPM_OFS_SUBOSC  6'h04
`define CGPM_OFS_WAIT    6'h08
`define CGPM_OFS_CKOUT   6'h0c
`define CGPM_OFS_MOFUNC  6'h10
`define CGPM_OFS_CLKDIV  6'h14
`define CGPM_OFS_MSTOP   6'h18
`define CGPM_OFS_PWR     6'h1c
`define CGPM_OFS_STATUS  6'h20
`define CGPM_OFS_MOSC    6'h24
`define CGPM_PLL_LSB     8
`define CGPM_PLL_MIN     6'h07
`define CGPM_PLL_MAX     6'h17
`define CGPM_PLL_RST     6'h07
`define CGPM_WAIT_MAX    5'h08
`define CGPM_WAIT_BASE   1024
`define CGPM_CKSEL_LSB   8
`define CGPM_CKDIV_LSB   12
`define CGPM_DRIVE_BIT   5
`define CGPM_MSTOP_RST   32'hffff_ffff
`define CGPM_RESP_OK     2'b00
`define CGPM_RESP_ERR    2'b10
`endif

// >>> verilog/cgpm_pkg.sv
// types of the clock generation and power mode block
package cgpm_pkg;
  // power state of the core
  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_DEEP, ST_STANDBY, ST_SNOOZE
  } cgpm_state_t;
  // operating power control mode
  typedef enum logic [1:0] {
    OPM_HIGH, OPM_MID, OPM_MID2, OPM_LOW
  } cgpm_opmode_t;
  // halt requests to the units of the core
  typedef struct packed {
    logic cpu_halt;
    logic ram_dtc_halt;
    logic flash_halt;
    logic periph_halt;
  } cgpm_halt_t;
  // independent divider ticks
  typedef struct packed {
    logic system_clock;
    logic peripheral_clock;
    logic converter_clock;
    logic flash_if_clock;
  } cgpm_ticks_t;
endpackage : cgpm_pkg

// >>> tb/cgpm_osc_model.sv
// free-running oscillator sources seen by the clock generation block
`timescale 1ns/1ps
`default_nettype none
module cgpm_osc_model #(
  parameter int HALF [6] = '{200, 150, 250, 350, 175, 225}
) (
  output var logic [5:0] osc
);
  // order: low, high, main, sub, pll, touch; the 3 ns offset keeps edges off ref_clk edges
  for (genvar i = 0; i < 6; i++) begin : g_osc
    // low speed source paces the stabilization wait count
    initial begin
      osc[i] = 1'b0;
      #3;
      forever #(HALF[i]) osc[i] = ~osc[i];
    end
  end
endmodule : cgpm_osc_model
`default_nettype wire

// >>> tb/clock_gen_and_power_modes_test.sv
// self-checking bench of the clock generation and power mode block
`timescale 1ns/1ps
`default_nettype none
module clock_gen_and_power_modes_test;
  localparam int HALF [6] = '{200, 150, 250, 350, 175, 225};
  logic ref_clk = '0, rst_n = '0, por_n = '0, awvalid = '0, wvalid = '0, bready = '0;
  logic arvalid = '0, rready = '0, wait_insn = '0, irq_pending = '0;
  logic snooze_req = '0, snooze_end = '0;
  logic [5:0] awaddr = '0, araddr = '0, osc;
  logic [31:0] wdata = '0, rdata, module_stop, rd_d, seed = 32'h649fd2f2;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, clock_output_pin, pll_code_ok, cpu_restart;
  logic main_osc_stop, main_osc_drive_bit, main_osc_stable, subclock_stop_bit;
  logic [6:0] pll_mult_x2;
  cgpm_pkg::cgpm_ticks_t  clk_ticks;
  cgpm_pkg::cgpm_opmode_t op_mode;
  cgpm_pkg::cgpm_halt_t   halt;
  cgpm_pkg::cgpm_state_t  state;
  int miscompares = 0;
  int cmp_count = 0;
  cgpm_osc_model #(.HALF(HALF)) osc_i (.osc(osc));
  cgpm_top #(.WAIT_BASE(4)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .por_n(por_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .low_speed_osc(osc[0]), .high_speed_osc(osc[1]),
    .main_osc(osc[2]), .sub_osc(osc[3]), .pll_clk(osc[4]), .touch_sensing_unit_clk(osc[5]),
    .wait_insn(wait_insn), .irq_pending(irq_pending), .snooze_req(snooze_req),
    .snooze_end(snooze_end), .clock_output_pin(clock_output_pin), .pll_mult_x2(pll_mult_x2),
    .pll_code_ok(pll_code_ok), .main_osc_stop(main_osc_stop),
    .main_osc_drive_bit(main_osc_drive_bit), .main_osc_stable(main_osc_stable),
    .subclock_stop_bit(subclock_stop_bit), .clk_ticks(clk_ticks), .module_stop(module_stop),
    .op_mode(op_mode), .halt(halt), .cpu_restart(cpu_restart), .state(state));
  // 20 MHz reference clock
  always #25 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next
  // expected stabilization wait in low speed counts
  function automatic int exp_wait(input int c);
    return (c == 0) ? 0 : (4 << (c - 1));
  endfunction : exp_wait
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic give_up;
    miscompares++;
    $display("wait limit reached at %0t", $time);
    stop_test;
  endtask : give_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // counts of edges taken in a window may be off by one at either end
  task automatic chk_near(input int got, input int exp);
    cmp_count++;
    if (got > exp + 1 || got < exp - 1) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_near
  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bit ta = 1'b0;
    bit tw = 1'b0;
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      if (ta && tw && bvalid === 1'b1) begin
        bready <= 1'b0;
        rsp = bresp;
        return;
      end
      if (awready === 1'b1) begin ta = 1'b1; awvalid <= 1'b0; end
      if (wready === 1'b1) begin tw = 1'b1; wvalid <= 1'b0; end
    end
    give_up;
  endtask : wr
  // axi4-lite read: rready held until rvalid
  task automatic rd(input logic [5:0] a);
    bit tk = 1'b0;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    repeat (100) begin
      @(posedge ref_clk);
      if (tk && rvalid === 1'b1) begin
        rready <= 1'b0;
        rd_d = rdata;
        rsp = rresp;
        return;
      end
      if (arready === 1'b1) begin tk = 1'b1; arvalid <= 1'b0; end
    end
    give_up;
  endtask : rd
  // program power control, execute the wait instruction, check the low power state
  task automatic lp(input logic [31:0] cfg, input logic [2:0] st, input logic [3:0] h);
    wr(6'h1c, cfg);
    wait_insn <= 1'b1;
    @(posedge ref_clk);
    wait_insn <= 1'b0;
    @(posedge ref_clk);
    chk(state, st);
    chk(halt, h);
    chk(op_mode, cfg[1:0]);
  endtask : lp
  // interrupt wakes the core, restart pulse lasts one cycle
  task automatic wake;
    irq_pending <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chk(state, 0);
    chk(cpu_restart, 1);
    chk(halt, 0);
    irq_pending <= 1'b0;
    snooze_end <= 1'b0;
    @(posedge ref_clk);
    chk(cpu_restart, 0);
  endtask : wake
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int n;
    int sel;
    int cnt [4];
    logic p;
    logic [2:0] dv;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1; por_n <= 1'b1;
    @(posedge ref_clk);
    chk(main_osc_stop, 1);
    chk(module_stop, 32'hffff_ffff);
    chk(subclock_stop_bit, 0);
    rd(6'h00);
    chk(rd_d, 32'h0000_0700);
    rd(6'h28);
    chk(rsp, 2);
    chk(rd_d, 32'h0);
    wr(6'h20, 32'hffff_ffff);
    chk(rsp, 2);
    $display("test reset and map done");
    for (int c = 6; c < 25; c++) begin
      wr(6'h00, 32'(c) << 8);
      chk(pll_mult_x2, c + 1);
      chk(pll_code_ok, (c >= 7 && c <= 23));
    end
    $display("test pll decode done");
    // codes 0 to 3 and the longest code 8
    for (int c = 0; c < 9; c = (c == 3) ? 8 : c + 1) begin
      wr(6'h08, 32'(c));
      wr(6'h24, 32'h0);
      chk(main_osc_stop, 0);
      n = 0;
      while (main_osc_stable !== 1'b1 && n < 5000) begin @(posedge ref_clk); n++; end
      if (main_osc_stable !== 1'b1) give_up;
      chk((n + 12 >= exp_wait(c) * 8) && (n <= exp_wait(c) * 8 + 12), 1);
      wr(6'h24, 32'h1);
      @(posedge ref_clk);
      chk(main_osc_stable, 0);
    end
    wr(6'h10, 32'h20);
    chk(main_osc_drive_bit, 1);
    wr(6'h10, 32'h0);
    chk(main_osc_drive_bit, 0);
    $display("test oscillator wait done");
    wr(6'h04, 32'h1);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(subclock_stop_bit, 1);
    por_n <= 1'b0; rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    por_n <= 1'b1; rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(subclock_stop_bit, 0);
    $display("test subclock stop done");
    for (int i = 0; i < 7; i++) begin
      sel = (i < 5) ? i : ((i == 5) ? 8 : 5);
      seed = lfsr_next(seed);
      dv = (i == 4) ? 3'h7 : {1'b0, seed[1:0]};
      wr(6'h0c, {17'h0, dv, 4'(sel), 8'h0});
      repeat (20) @(posedge ref_clk);
      n = 0;
      p = clock_output_pin;
      repeat (2000) begin
        @(posedge ref_clk);
        if (clock_output_pin === 1'b1 && p === 1'b0) n++;
        p = clock_output_pin;
      end
      chk_near(n, (i == 6) ? 0 : 100000 / ((2 * HALF[i % 6]) << dv));
    end
    $display("test clock output done");
    repeat (2) begin
      seed = lfsr_next(seed);
      wr(6'h14, seed & 32'h7777);
      cnt = '{0, 0, 0, 0};
      repeat (256) begin
        @(posedge ref_clk);
        for (int k = 0; k < 4; k++) cnt[k] += (clk_ticks[3 - k] === 1'b1);
      end
      for (int k = 0; k < 4; k++) chk_near(cnt[k], 256 >> seed[4 * k +: 3]);
      seed = lfsr_next(seed);
      wr(6'h18, seed);
      chk(module_stop, seed);
      rd(6'h18);
      chk(rd_d, seed);
    end
    $display("test dividers and module stop done");
    for (int m = 0; m < 4; m++) begin
      lp(32'(m), 1, 4'h8);
      wake;
      lp(32'h20 | m, 2, 4'he);
      wake;
      lp(32'hc0 | m, 3, 4'hf);
      snooze_req <= 1'b1;
      @(posedge ref_clk);
      @(posedge ref_clk);
      chk(state, 4);
      chk(halt, 4'ha);
      snooze_req <= 1'b0;
      snooze_end <= 1'b1;
      wake;
    end
    $display("test power modes done");
    stop_test;
  end
endmodule : clock_gen_and_power_modes_test
`default_nettype wire
